//--- ctp_rx_tag_parser.sv
module ctp_rx_tag_parser
    import ctp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic [7:0] rx_data,
    input wire logic rx_is_cpu_port,
    input wire logic rx_cmd_tag_enable,
    input wire logic [15:0] cmd_tag_type_value,
    input wire logic [PORT_CNT-1:0] dflt_port_map,
    input wire logic dflt_learn,
    input wire logic [1:0] dflt_queue,
    output logic tag_done,
    output logic tag_accepted,
    output logic dst_map_valid,
    output logic [PORT_CNT-1:0] dst_map,
    output logic mirror_valid,
    output logic mirror,
    output logic mgmt_valid,
    output logic mgmt,
    output logic xdom_valid,
    output logic xdom,
    output logic learn_flag_valid,
    output logic learn_flag,
    output logic queue_sel_valid,
    output logic [1:0] queue_sel,
    output logic egress_tag_ctl_valid,
    output logic [1:0] egress_tag_ctl,
    output logic member_valid,
    output logic [PORT_CNT-1:0] member_map,
    output logic [PORT_CNT-1:0] fwd_port_map,
    output logic fwd_learn,
    output logic [1:0] fwd_queue
);
    typedef struct packed {
        ctp_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [TAG_W-1:0] tag;
        logic done;
        logic hit;
        ctp_fields_t f;
        logic [PORT_CNT-1:0] fwd_map;
        logic fwd_learn;
        logic [1:0] fwd_queue;
    } ctp_regs_t;

    ctp_regs_t r_reg;
    ctp_regs_t r_next;
    logic [1:0] rst_sync_reg;
    logic rst_int_n;
    logic [2:0] k;

    ctp_tag_if tif ();

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_reg[1];

    assign tif.tag_bytes = r_reg.tag;
    assign tif.cmd_tag_type_value = cmd_tag_type_value;

    ctp_tag_decode u_dec (
        .tif(tif)
    );

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        k = 3'(r_reg.cnt - TAG_START);
        case (r_reg.st)
            ST_HDR: begin
                if (rx_valid) begin
                    if (r_reg.cnt >= TAG_START && r_reg.cnt <= TAG_LAST) begin
                        r_next.tag[8*k +: 8] = rx_data;
                    end
                    r_next.cnt = r_reg.cnt + CNT_FIRST;
                    if (r_reg.cnt == TAG_LAST) begin
                        r_next.st = ST_EVAL;
                    end else if (rx_eof) begin
                        r_next.st = ST_IDLE;
                    end
                end
            end
            ST_EVAL: begin
                r_next.done = 1'b1;
                r_next.hit = tif.prefix_match;
                // rejected tags report no valid field at all
                r_next.f = tif.prefix_match ? tif.fields : '0;
                r_next.fwd_map = dflt_port_map;
                r_next.fwd_learn = dflt_learn;
                r_next.fwd_queue = dflt_queue;
                if (tif.prefix_match && tif.fields.map_valid) begin
                    r_next.fwd_map = tif.fields.map;
                end
                if (tif.prefix_match && tif.fields.learn_flag_valid) begin
                    r_next.fwd_learn = tif.fields.learn_flag;
                end
                if (tif.prefix_match && tif.fields.queue_sel_valid) begin
                    r_next.fwd_queue = tif.fields.queue_sel;
                end
                r_next.st = ST_SKIP;
            end
            ST_IDLE, ST_SKIP: begin
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        if (rx_valid && rx_sof) begin
            r_next.cnt = CNT_FIRST;
            r_next.hit = 1'b0;
            r_next.f = '0;
            if (rx_is_cpu_port && rx_cmd_tag_enable) begin
                r_next.st = ST_HDR;
            end else begin
                r_next.st = ST_SKIP;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tag_done = r_reg.done;
    assign tag_accepted = r_reg.hit;
    assign dst_map_valid = r_reg.f.map_valid;
    assign dst_map = r_reg.f.map;
    assign mirror_valid = r_reg.f.mirror_valid;
    assign mirror = r_reg.f.mirror;
    assign mgmt_valid = r_reg.f.mgmt_valid;
    assign mgmt = r_reg.f.mgmt;
    assign xdom_valid = r_reg.f.xdom_valid;
    assign xdom = r_reg.f.xdom;
    assign learn_flag_valid = r_reg.f.learn_flag_valid;
    assign learn_flag = r_reg.f.learn_flag;
    assign queue_sel_valid = r_reg.f.queue_sel_valid;
    assign queue_sel = r_reg.f.queue_sel;
    assign egress_tag_ctl_valid = r_reg.f.egress_tag_ctl_valid;
    assign egress_tag_ctl = r_reg.f.egress_tag_ctl;
    assign member_valid = r_reg.f.member_valid;
    assign member_map = r_reg.f.member_map;
    assign fwd_port_map = r_reg.fwd_map;
    assign fwd_learn = r_reg.fwd_learn;
    assign fwd_queue = r_reg.fwd_queue;
endmodule // ctp_rx_tag_parser

//--- ctp_pkg.sv
// Contract
// - six tag bytes sit after preamble and both addresses, before vlan tag
// - tag parsed only on cpu port frames while rx_cmd_tag_enable is set
// - prefix bytes 0,1 must equal cmd_tag_type_value, else tag ignored
// - matching prefix makes the tag contents steer switching of that frame
// - byte 2: bit 7 ignored, bit 6 map valid, bits 5:0 destination map
// - byte 3: bit 7 mirror valid, bit 6 mirror flag
// - byte 3: bit 5 management valid, bit 4 management flag
// - byte 3: bit 3 cross-domain valid, bit 2 cross-domain flag
// - byte 3: bit 1 learn_flag_valid, bit 0 learn_flag
// - byte 4: 6 queue valid, 5:4 queue, 2 egress valid, 1:0 egress ctl
// - byte 5: bit 6 tagged-member valid, bits 5:0 tagged-member port map
// - valid tag destination map overrides learned and default port maps
package ctp_pkg;
    localparam int PREAMBLE_LEN = 8;
    localparam int ADDR_LEN = 6;
    localparam int TAG_LEN = 6;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] TAG_START = CNT_W'(PREAMBLE_LEN
                                                   + 2 * ADDR_LEN);
    localparam logic [CNT_W-1:0] TAG_LAST = CNT_W'(PREAMBLE_LEN + 2 * ADDR_LEN
                                                  + TAG_LEN - 1);
    localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
    localparam int PORT_CNT = 6;
    localparam int TAG_W = 8 * TAG_LEN;
    // byte offsets inside the tag
    localparam int B_PFX0 = 0;
    localparam int B_PFX1 = 1;
    localparam int B_MAP = 2;
    localparam int B_FLAGS = 3;
    localparam int B_QOS = 4;
    localparam int B_MEMBER = 5;
    // bit positions
    localparam int MAP_VALID_BIT = 6;
    localparam int MIRROR_VALID_BIT = 7;
    localparam int MIRROR_BIT = 6;
    localparam int MGMT_VALID_BIT = 5;
    localparam int MGMT_BIT = 4;
    localparam int XDOM_VALID_BIT = 3;
    localparam int XDOM_BIT = 2;
    localparam int LEARN_VALID_BIT = 1;
    localparam int LEARN_BIT = 0;
    localparam int QUEUE_VALID_BIT = 6;
    localparam int QUEUE_LSB = 4;
    localparam int EGRESS_VALID_BIT = 2;
    localparam int EGRESS_LSB = 0;
    localparam int MEMBER_VALID_BIT = 6;

    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_EVAL, ST_SKIP} ctp_state_t;

    typedef struct packed {
        logic map_valid;
        logic [PORT_CNT-1:0] map;
        logic mirror_valid;
        logic mirror;
        logic mgmt_valid;
        logic mgmt;
        logic xdom_valid;
        logic xdom;
        logic learn_flag_valid;
        logic learn_flag;
        logic queue_sel_valid;
        logic [1:0] queue_sel;
        logic egress_tag_ctl_valid;
        logic [1:0] egress_tag_ctl;
        logic member_valid;
        logic [PORT_CNT-1:0] member_map;
    } ctp_fields_t;
endpackage

//--- ctp_tag_if.sv
interface ctp_tag_if;
    import ctp_pkg::*;
    logic [TAG_W-1:0] tag_bytes;
    logic [15:0] cmd_tag_type_value;
    logic prefix_match;
    ctp_fields_t fields;
    modport src (output tag_bytes, output cmd_tag_type_value,
                 input prefix_match, input fields);
    modport dec (input tag_bytes, input cmd_tag_type_value,
                 output prefix_match, output fields);
endinterface

//--- ctp_tag_decode.sv
module ctp_tag_decode
    import ctp_pkg::*;
(
    ctp_tag_if.dec tif
);
    logic [7:0] tag_prefix_byte0;
    logic [7:0] tag_prefix_byte1;
    logic [7:0] b_map;
    logic [7:0] b_flags;
    logic [7:0] b_qos;
    logic [7:0] b_member;

    assign tag_prefix_byte0 = tif.tag_bytes[8*B_PFX0 +: 8];
    assign tag_prefix_byte1 = tif.tag_bytes[8*B_PFX1 +: 8];
    assign b_map = tif.tag_bytes[8*B_MAP +: 8];
    assign b_flags = tif.tag_bytes[8*B_FLAGS +: 8];
    assign b_qos = tif.tag_bytes[8*B_QOS +: 8];
    assign b_member = tif.tag_bytes[8*B_MEMBER +: 8];

    assign tif.prefix_match = ({tag_prefix_byte0, tag_prefix_byte1}
                               == tif.cmd_tag_type_value);
    assign tif.fields.map_valid = b_map[MAP_VALID_BIT];
    assign tif.fields.map = b_map[PORT_CNT-1:0];
    assign tif.fields.mirror_valid = b_flags[MIRROR_VALID_BIT];
    assign tif.fields.mirror = b_flags[MIRROR_BIT];
    assign tif.fields.mgmt_valid = b_flags[MGMT_VALID_BIT];
    assign tif.fields.mgmt = b_flags[MGMT_BIT];
    assign tif.fields.xdom_valid = b_flags[XDOM_VALID_BIT];
    assign tif.fields.xdom = b_flags[XDOM_BIT];
    assign tif.fields.learn_flag_valid = b_flags[LEARN_VALID_BIT];
    assign tif.fields.learn_flag = b_flags[LEARN_BIT];
    assign tif.fields.queue_sel_valid = b_qos[QUEUE_VALID_BIT];
    assign tif.fields.queue_sel = b_qos[QUEUE_LSB +: 2];
    assign tif.fields.egress_tag_ctl_valid = b_qos[EGRESS_VALID_BIT];
    assign tif.fields.egress_tag_ctl = b_qos[EGRESS_LSB +: 2];
    assign tif.fields.member_valid = b_member[MEMBER_VALID_BIT];
    assign tif.fields.member_map = b_member[PORT_CNT-1:0];
endmodule // ctp_tag_decode

//--- ctp_rx_tag_parser_asserts.sv
module ctp_rx_tag_parser_asserts
    import ctp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire logic rx_sof,
    input wire logic rx_is_cpu_port,
    input wire logic rx_cmd_tag_enable,
    input wire logic dflt_learn,
    input wire logic tag_done,
    input wire logic tag_accepted,
    input wire logic dst_map_valid,
    input wire logic mirror_valid,
    input wire logic mirror,
    input wire logic mgmt_valid,
    input wire logic mgmt,
    input wire logic xdom_valid,
    input wire logic xdom,
    input wire logic learn_flag_valid,
    input wire logic learn_flag,
    input wire logic queue_sel_valid,
    input wire logic egress_tag_ctl_valid,
    input wire logic member_valid,
    input wire logic fwd_learn,
    input wire logic [7:0] rx_data,
    input wire logic [15:0] cmd_tag_type_value,
    input wire logic [1:0] dflt_queue,
    input wire logic [1:0] queue_sel,
    input wire logic [1:0] egress_tag_ctl,
    input wire logic [1:0] fwd_queue,
    input wire logic [PORT_CNT-1:0] dflt_port_map,
    input wire logic [PORT_CNT-1:0] dst_map,
    input wire logic [PORT_CNT-1:0] member_map,
    input wire logic [PORT_CNT-1:0] fwd_port_map
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] pos_reg;
    logic [47:0] tag_reg;
    logic gate_reg;
    logic on_tag;
    logic [27:0] fld;
    assign on_tag = rx_valid && !rx_sof && pos_reg >= TAG_START
                    && pos_reg <= TAG_LAST;
    assign fld = {dst_map_valid, dst_map, mirror_valid, mirror, mgmt_valid,
                  mgmt, xdom_valid, xdom, learn_flag_valid, learn_flag,
                  queue_sel_valid, queue_sel, egress_tag_ctl_valid,
                  egress_tag_ctl, member_valid, member_map};
    // stream position and captured tag bytes, tag byte 0 on top
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_reg <= 5'h00;
            tag_reg <= 48'h0;
            gate_reg <= 1'b0;
        end else if (rx_valid) begin
            pos_reg <= rx_sof ? 5'h01 : pos_reg + {4'h0, pos_reg != 5'h1F};
            if (rx_sof) gate_reg <= rx_is_cpu_port && rx_cmd_tag_enable;
            if (on_tag) tag_reg <= {tag_reg[39:0], rx_data};
        end
    end
    sequence s_last_tag_byte;
        rx_valid && !rx_sof && pos_reg == TAG_LAST && gate_reg;
    endsequence
    sequence s_answer;
        !tag_done ##1 tag_done;
    endsequence
    property p_done_time; s_last_tag_byte |=> s_answer; endproperty
    a_done_time: assert property (p_done_time) else $error("late done");
    property p_done_pulse; tag_done |=> !tag_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("stuck");
    property p_gate; tag_done |-> gate_reg; endproperty
    a_gate: assert property (p_gate) else $error("tag parsed off");
    property p_sof_clear;
        rx_valid && rx_sof |=> !tag_accepted && fld == 28'h0;
    endproperty
    a_sof_clear: assert property (p_sof_clear) else $error("no clear");
    property p_prefix;
        tag_done |-> tag_accepted
            == (tag_reg[47:32] == $past(cmd_tag_type_value));
    endproperty
    a_prefix: assert property (p_prefix) else $error("prefix wrong");
    property p_fields;
        tag_done |-> fld == (tag_accepted ? {tag_reg[30:16], tag_reg[14:12],
                             tag_reg[10:8], tag_reg[6:0]} : 28'h0);
    endproperty
    a_fields: assert property (p_fields) else $error("fields wrong");
    property p_fwd_map; tag_done |-> fwd_port_map == (tag_accepted
        && dst_map_valid ? dst_map : $past(dflt_port_map)); endproperty
    a_fwd_map: assert property (p_fwd_map) else $error("map wrong");
    property p_fwd_rest; tag_done |-> fwd_learn == (learn_flag_valid
        ? learn_flag : $past(dflt_learn)) && fwd_queue == (queue_sel_valid
        ? queue_sel : $past(dflt_queue)); endproperty
    a_fwd_rest: assert property (p_fwd_rest) else $error("fallback");
endmodule // ctp_rx_tag_parser_asserts
bind ctp_rx_tag_parser ctp_rx_tag_parser_asserts u_chk (.*);

//--- ctp_host_model.sv
module ctp_host_model (
    input wire logic ref_clk,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic [7:0] rx_data,
    output logic rx_is_cpu_port,
    output logic rx_cmd_tag_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {rx_valid, rx_sof, rx_eof, rx_is_cpu_port, rx_cmd_tag_enable} = 5'h00;
        rx_data = 8'h00;
    end
    // md is {short frame, enable, cpu port}; gap stalls every fifth byte
    task automatic send(input logic [47:0] tag, input logic [2:0] md,
                        input logic gap);
        logic [7:0] b;
        int n;
        n = md[2] ? 25 : 30;
        for (int i = 0; i < n; i++) begin
            b = i < 7 ? 8'h55 : i < 8 ? 8'hD5 : i < 20 ? 8'(i * 3)
                : i < 26 ? tag[8 * (25 - i) +: 8] : 8'(~i);
            @(posedge ref_clk) #1;
            {rx_valid, rx_sof, rx_eof} = {1'b1, i == 0, i == n - 1};
            {rx_is_cpu_port, rx_cmd_tag_enable} = {md[0], md[1]};
            rx_data = b;
            if (gap && i % 5 == 4) begin
                @(posedge ref_clk) #1;
                {rx_valid, rx_data} = {1'b0, ~rx_data};
            end
        end
        @(posedge ref_clk) #1;
        {rx_valid, rx_data} = {1'b0, ~rx_data};
    endtask
endmodule // ctp_host_model

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
    localparam logic [15:0] TYPE_VAL = 16'hA55A;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic dflt_learn = 1'b0;
    logic [1:0] dflt_queue = 2'h0;
    logic [5:0] dflt_port_map = 6'h00;
    logic [15:0] cmd_tag_type_value = TYPE_VAL;
    logic rx_valid, rx_sof, rx_eof, rx_is_cpu_port, rx_cmd_tag_enable;
    logic tag_done, tag_accepted, dst_map_valid, mirror_valid, mirror;
    logic mgmt_valid, mgmt, xdom_valid, xdom, learn_flag_valid, learn_flag;
    logic queue_sel_valid, egress_tag_ctl_valid, member_valid, fwd_learn;
    logic [7:0] rx_data;
    logic [1:0] queue_sel, egress_tag_ctl, fwd_queue;
    logic [5:0] dst_map, member_map, fwd_port_map;
    int bad_count = 0;
    int n_tests = 0;
    wire [27:0] fld = {dst_map_valid, dst_map, mirror_valid, mirror,
        mgmt_valid, mgmt, xdom_valid, xdom, learn_flag_valid, learn_flag,
        queue_sel_valid, queue_sel, egress_tag_ctl_valid, egress_tag_ctl,
        member_valid, member_map};
    logic [47:0] tg [9] = '{48'hA55A_EA_FF_777F, 48'hA55A_95_AA_88BF,
        48'hA55A_41_55_5041, 48'hA55A_7F_03_6400, 48'hA45A_EA_FF_777F,
        48'hA55B_EA_FF_777F, 48'hA55A_EA_FF_777F, 48'hA55A_EA_FF_777F,
        48'hA55A_EA_FF_777F};
    logic [2:0] md [9] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h1,
        3'h7};
    always #10 ref_clk = ~ref_clk;
    ctp_host_model u_host (.*);
    ctp_rx_tag_parser u_dut (.*);
    task automatic conclude();
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic run(input int k);
        logic [47:0] t;
        logic acc;
        logic seen;
        t = tg[k];
        acc = md[k] == 3'h3 && t[47:32] == TYPE_VAL;
        seen = 1'b0;
        @(posedge ref_clk) #1;
        dflt_port_map = 6'(k * 7);
        dflt_learn = k[0];
        dflt_queue = 2'(k);
        fork
            u_host.send(t, md[k], k[0]);
            begin
                for (int c = 0; c < 40 && !seen; c++) begin
                    @(posedge ref_clk) #2;
                    seen = tag_done === 1'b1;
                end
                `CHK("tag_done", md[k] == 3'h3, seen)
                `CHK("accepted", acc, tag_accepted)
                `CHK("fields", acc ? {t[30:16], t[14:12], t[10:8], t[6:0]}
                     : 28'h0, fld)
                if (seen) begin
                    `CHK("fwd_map", acc && t[30] ? t[29:24] : dflt_port_map,
                         fwd_port_map)
                    `CHK("fwd_learn", acc && t[17] ? t[16] : dflt_learn,
                         fwd_learn)
                    `CHK("fwd_queue", acc && t[14] ? t[13:12] : dflt_queue,
                         fwd_queue)
                end
            end
        join
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int k = 0; k < 9; k++) run(k);
        conclude();
    end
endmodule // testbench
